// *** rtl/lic_charge_sequencer.sv ***
// Contract
// - Charge starts only with power and enable
// - Power present output low when supply seen
// - Both supplies present: charge through wall path
// - End-of-charge driven low at cycle start
// - Low battery at start enters trickle mode
// - Above threshold leave trickle, enter fast charge
// - Near charge voltage move to constant voltage
// - Ten percent current: release flag, maintenance
// - Maintenance holds until disable or unplug
// - Config bits 4:3 select charge voltage
// - Config bits 7:6 select USB current
// - USB-only input uses USB current field
// - Fast charge runs watchdog; expiry stops charge except in maintenance
// - Cycle started in trickle keeps watchdog off
// - Fall back fast to trickle keeps watchdog
// - Watchdog period 1, 15, 30, 60 minutes
// - Refresh bit or unplug restarts watchdog count
// - Control bit enables or disables watchdog
// - Reset: watchdog enabled, one minute period
`timescale 1ns/1ns
module lic_charge_sequencer #(
    parameter longint WD_MINUTE_CYCLES = lic_pkg::LIC_WD_MINUTE_CYCLES
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire lic_pkg::lic_sense_s sense,
    input wire logic reg_wr,
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic power_present_n,
    output logic end_of_charge_n_out,
    output logic end_of_charge_n_oe,
    output lic_pkg::lic_drive_s drive,
    output logic wd_expired
);
    import lic_pkg::*;

    // Register file
    logic [7:0] charge_config_reg; // Voltage, source select, USB current
    logic [7:0] charge_control_reg; // Enable, watchdog enable and period
    logic [7:0] next_config;
    logic [7:0] next_control;
    logic [7:0] next_rdata;
    logic refresh_wr; // One-cycle pulse, never stored
    logic power_seen;
    logic [7:0] status_word;
    lic_state_e state;
    lic_state_e next_state;

    // Register port decode; refresh bit is write-only and self-clearing
    always_comb begin
        next_config = charge_config_reg;
        next_control = charge_control_reg;
        refresh_wr = 1'b0;
        if (reg_wr && reg_addr == LIC_ADDR_CONFIG) begin
            next_config = reg_wdata;
        end
        if (reg_wr && reg_addr == LIC_ADDR_CONTROL) begin
            next_control = reg_wdata;
            next_control[LIC_CTL_WD_REFRESH_BIT] = 1'b0;
            refresh_wr = reg_wdata[LIC_CTL_WD_REFRESH_BIT];
        end
        case (reg_addr)
            LIC_ADDR_CONFIG: next_rdata = charge_config_reg;
            LIC_ADDR_CONTROL: next_rdata = charge_control_reg;
            LIC_ADDR_STATUS: next_rdata = status_word;
            default: next_rdata = 8'h00; // Unmapped reads zero
        endcase
    end

    // Register state
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            charge_config_reg <= LIC_CFG_RESET;
            charge_control_reg <= LIC_CTL_RESET;
            reg_rdata <= 8'h00;
        end else begin
            charge_config_reg <= next_config;
            charge_control_reg <= next_control;
            reg_rdata <= next_rdata;
        end
    end

    // Field views
    logic chg_en;
    logic wd_en;
    logic [1:0] wd_period;
    logic src_usb;
    logic [1:0] usb_isel;
    assign chg_en = charge_control_reg[LIC_CTL_ENABLE_BIT];
    assign wd_en = charge_control_reg[LIC_CTL_WD_EN_BIT];
    assign wd_period = charge_control_reg[LIC_CTL_WD_PER_LSB +: 2];
    assign src_usb = charge_config_reg[LIC_CFG_SRC_SEL_BIT];
    assign usb_isel = charge_config_reg[LIC_CFG_USB_I_LSB +: 2];
    assign power_seen = sense.main_detect | sense.usb_supply_input;

    // Watchdog
    logic [LIC_WD_CNT_W-1:0] wd_count;
    logic [LIC_WD_CNT_W-1:0] next_wd_count;
    logic [LIC_WD_CNT_W-1:0] wd_limit;
    logic wd_armed; // Set once fast charge has run this cycle
    logic next_wd_armed;
    logic wd_fire;
    logic prev_power; // Detects unplug edge
    logic unplug;

    assign unplug = prev_power & ~power_seen;

    // Period select; counts are cycles, minute count is a parameter
    always_comb begin
        case (wd_period)
            LIC_WD_1MIN: wd_limit = LIC_WD_CNT_W'(WD_MINUTE_CYCLES);
            LIC_WD_15MIN: wd_limit = LIC_WD_CNT_W'(WD_MINUTE_CYCLES * LIC_WD_MULT_15);
            LIC_WD_30MIN: wd_limit = LIC_WD_CNT_W'(WD_MINUTE_CYCLES * LIC_WD_MULT_30);
            default: wd_limit = LIC_WD_CNT_W'(WD_MINUTE_CYCLES * LIC_WD_MULT_60);
        endcase
    end

    assign wd_fire = wd_armed && wd_en && (wd_count >= wd_limit - 1'b1) && !refresh_wr;

    // Watchdog next values
    always_comb begin
        next_wd_count = wd_count;
        next_wd_armed = wd_armed;
        if (next_state == LIC_ST_FAST) begin
            next_wd_armed = 1'b1;
        end else if (next_state == LIC_ST_IDLE) begin
            next_wd_armed = 1'b0; // Fresh cycle may start in trickle
        end
        // Trickle after fast keeps the armed flag untouched
        if (refresh_wr || unplug || !wd_armed || !wd_en || state == LIC_ST_HALT) begin
            next_wd_count = '0;
        end else begin
            next_wd_count = wd_count + 1'b1;
        end
    end

    // Watchdog registers
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            wd_count <= '0;
            wd_armed <= 1'b0;
            prev_power <= 1'b0;
        end else begin
            wd_count <= next_wd_count;
            wd_armed <= next_wd_armed;
            prev_power <= power_seen;
        end
    end

    // Charge sequence next state
    always_comb begin
        next_state = state;
        if (!chg_en || !power_seen) begin
            next_state = LIC_ST_IDLE;
        end else begin
            case (state)
                LIC_ST_IDLE: begin
                    // Trickle figures are fixed in the analog comparator
                    if (sense.batt_below_trickle) begin
                        next_state = LIC_ST_TRICKLE;
                    end else begin
                        next_state = LIC_ST_FAST;
                    end
                end
                LIC_ST_TRICKLE: begin
                    if (wd_fire) begin
                        next_state = LIC_ST_HALT;
                    end else if (!sense.batt_below_trickle) begin
                        next_state = LIC_ST_FAST;
                    end
                end
                LIC_ST_FAST: begin
                    if (wd_fire) begin
                        next_state = LIC_ST_HALT;
                    end else if (sense.batt_below_trickle) begin
                        next_state = LIC_ST_TRICKLE;
                    end else if (sense.batt_near_vcharge) begin
                        next_state = LIC_ST_CV;
                    end
                end
                LIC_ST_CV: begin
                    if (wd_fire) begin
                        next_state = LIC_ST_HALT;
                    end else if (sense.current_below_eoc) begin
                        next_state = LIC_ST_MAINT;
                    end
                end
                LIC_ST_MAINT: next_state = LIC_ST_MAINT;
                LIC_ST_HALT: begin
                    if (refresh_wr) begin
                        next_state = LIC_ST_IDLE;
                    end
                end
                default: next_state = LIC_ST_IDLE;
            endcase
        end
    end

    // Charge sequence register
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state <= LIC_ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Output drive next values
    lic_drive_s next_drive;
    logic next_eoc_oe;
    logic next_pp_n;
    logic charging;
    logic use_main;
    logic usb_current;

    assign charging = (state == LIC_ST_TRICKLE) || (state == LIC_ST_FAST) || (state == LIC_ST_CV)
        || (state == LIC_ST_MAINT);
    assign use_main = sense.main_detect; // Wall wins when both present
    // USB field applies on USB-only input whatever the select bit says
    assign usb_current = !use_main || src_usb;

    always_comb begin
        next_drive = '0;
        next_drive.vcharge_select = charge_config_reg[LIC_CFG_VCHG_LSB +: 2];
        next_drive.usb_current_select = usb_isel;
        next_drive.main_path_en = charging && use_main;
        next_drive.usb_path_en = charging && !use_main;
        next_drive.trickle_on = (state == LIC_ST_TRICKLE);
        // USB code 11 turns the fast source off when the USB current field applies
        next_drive.fast_on = (state == LIC_ST_FAST) && !(usb_current && usb_isel == LIC_USB_OFF);
        next_drive.cv_on = (state == LIC_ST_CV) || (state == LIC_ST_MAINT);
        next_drive.fast_from_rset = use_main && !src_usb;
        // Low from cycle start until end of charge
        next_eoc_oe = (next_state == LIC_ST_TRICKLE) || (next_state == LIC_ST_FAST)
            || (next_state == LIC_ST_CV);
        next_pp_n = !power_seen;
    end

    // Output registers
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            drive <= '0;
            end_of_charge_n_oe <= 1'b0;
            power_present_n <= 1'b1;
            wd_expired <= 1'b0;
        end else begin
            drive <= next_drive;
            end_of_charge_n_oe <= next_eoc_oe;
            power_present_n <= next_pp_n;
            wd_expired <= (next_state == LIC_ST_HALT);
        end
    end

    // Open drain: only ever pulls low
    assign end_of_charge_n_out = 1'b0;
    assign status_word = {1'b0, wd_armed, state};

    // Checks
    sequence s_fast_taken;
        state == LIC_ST_FAST;
    endsequence

    sequence s_trickle_next;
        ##1 state == LIC_ST_TRICKLE;
    endsequence

    AST_NO_CHARGE_DISABLED: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !chg_en |=> state == LIC_ST_IDLE)
        else $error("Charger left idle while disabled");

    AST_POWER_PRESENT: assert property (@(posedge clk_sys) disable iff (sys_rst)
        power_seen |=> !power_present_n)
        else $error("Power present not asserted");

    AST_WALL_PRIORITY: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (sense.main_detect && sense.usb_supply_input && charging) |=> !drive.usb_path_en)
        else $error("USB path used while wall present");

    AST_EOC_LOW_AT_START: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (state == LIC_ST_IDLE && chg_en && power_seen) |=> end_of_charge_n_oe)
        else $error("End of charge not pulled low at start");

    AST_TRICKLE_START: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (state == LIC_ST_IDLE && chg_en && power_seen && sense.batt_below_trickle) |=> state == LIC_ST_TRICKLE)
        else $error("Low battery did not enter trickle");

    AST_TRICKLE_NO_WD: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (state == LIC_ST_IDLE) ##1 (state == LIC_ST_TRICKLE) |-> !wd_armed)
        else $error("Watchdog armed on trickle start");

    AST_FALLBACK_KEEPS_WD: assert property (@(posedge clk_sys) disable iff (sys_rst)
        s_fast_taken ##0 s_trickle_next |-> wd_armed)
        else $error("Watchdog dropped on fall back");

    AST_EOC_RELEASE: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (state == LIC_ST_CV && sense.current_below_eoc && chg_en && power_seen && !wd_fire)
        |=> (state == LIC_ST_MAINT) ##0 !end_of_charge_n_oe)
        else $error("End of charge not released");

    AST_WD_EXPIRY_HALTS: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (wd_fire && chg_en && power_seen && state == LIC_ST_FAST) |=> state == LIC_ST_HALT ##0 wd_expired)
        else $error("Watchdog expiry did not stop charge");

    AST_REFRESH_RESTARTS: assert property (@(posedge clk_sys) disable iff (sys_rst)
        refresh_wr |=> wd_count == '0)
        else $error("Refresh did not restart watchdog");

    AST_HALT_HOLDS: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (state == LIC_ST_HALT && !refresh_wr && chg_en && power_seen) |=> state == LIC_ST_HALT)
        else $error("Halt released without cause");

    // Unplug edge must restart the count even mid fast charge
    AST_UNPLUG_RESTARTS: assert property (@(posedge clk_sys) disable iff (sys_rst)
        unplug |=> wd_count == '0)
        else $error("Unplug did not restart watchdog");

    AST_WD_DISABLED_HOLDS: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !wd_en |=> wd_count == '0)
        else $error("Watchdog counted while disabled");

    AST_TRICKLE_TO_FAST: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (state == LIC_ST_TRICKLE && chg_en && power_seen && !wd_fire && !sense.batt_below_trickle)
        |=> state == LIC_ST_FAST)
        else $error("Trickle did not advance to fast charge");

    AST_FAST_TO_CV: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (state == LIC_ST_FAST && chg_en && power_seen && !wd_fire && !sense.batt_below_trickle
        && sense.batt_near_vcharge) |=> state == LIC_ST_CV)
        else $error("Near charge voltage did not enter constant voltage");

    AST_MAINT_HOLDS: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (state == LIC_ST_MAINT && chg_en && power_seen) |=> state == LIC_ST_MAINT)
        else $error("Maintenance left while enabled and powered");

    AST_USB_ONLY_PATH: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (!sense.main_detect && charging) |=> drive.usb_path_en && !drive.main_path_en)
        else $error("USB-only charge not routed through USB path");

    AST_TRICKLE_DRIVE: assert property (@(posedge clk_sys) disable iff (sys_rst)
        state == LIC_ST_TRICKLE |=> drive.trickle_on && !drive.fast_on)
        else $error("Trickle source not driven alone");
endmodule : lic_charge_sequencer

// *** rtl/lic_pkg.sv ***
package lic_pkg;
    // Register indices on the internal register port
    localparam logic [1:0] LIC_ADDR_CONFIG = 2'h0;
    localparam logic [1:0] LIC_ADDR_CONTROL = 2'h1;
    localparam logic [1:0] LIC_ADDR_STATUS = 2'h2;

    // Charge configuration register fields
    localparam int LIC_CFG_VCHG_LSB = 3;
    localparam int LIC_CFG_SRC_SEL_BIT = 5;
    localparam int LIC_CFG_USB_I_LSB = 6;
    localparam logic [7:0] LIC_CFG_RESET = 8'h00;

    // Charge control register fields
    localparam int LIC_CTL_ENABLE_BIT = 0;
    localparam int LIC_CTL_WD_EN_BIT = 1;
    localparam int LIC_CTL_WD_PER_LSB = 2;
    localparam int LIC_CTL_WD_REFRESH_BIT = 4;
    localparam logic [7:0] LIC_CTL_RESET = 8'h02;

    // Charge voltage codes
    localparam logic [1:0] LIC_VCHG_4V10 = 2'h0;
    localparam logic [1:0] LIC_VCHG_4V20 = 2'h1;
    localparam logic [1:0] LIC_VCHG_4V30 = 2'h2;
    localparam logic [1:0] LIC_VCHG_4V35 = 2'h3;

    // USB current codes
    localparam logic [1:0] LIC_USB_60MA = 2'h0;
    localparam logic [1:0] LIC_USB_200MA = 2'h1;
    localparam logic [1:0] LIC_USB_400MA = 2'h2;
    localparam logic [1:0] LIC_USB_OFF = 2'h3;

    // Watchdog period codes, in minutes 1, 15, 30, 60
    localparam logic [1:0] LIC_WD_1MIN = 2'h0;
    localparam logic [1:0] LIC_WD_15MIN = 2'h1;
    localparam logic [1:0] LIC_WD_30MIN = 2'h2;
    localparam logic [1:0] LIC_WD_60MIN = 2'h3;

    // Timing
    localparam longint LIC_CLK_HZ = 100_000_000;
    localparam longint LIC_WD_MINUTE_S = 60;
    localparam longint LIC_WD_MINUTE_CYCLES = LIC_CLK_HZ * LIC_WD_MINUTE_S;
    localparam int LIC_WD_CNT_W = 40;
    // Period multipliers of the minute count
    localparam longint LIC_WD_MULT_15 = 64'hf;
    localparam longint LIC_WD_MULT_30 = 64'h1e;
    localparam longint LIC_WD_MULT_60 = 64'h3c;

    // Fixed trickle figures, informative only
    localparam int LIC_TRICKLE_MA = 60;
    localparam int LIC_TRICKLE_MV = 2900;

    // Charger modes, one-hot
    typedef enum logic [5:0] {
        LIC_ST_IDLE = 6'h01,
        LIC_ST_TRICKLE = 6'h02,
        LIC_ST_FAST = 6'h04,
        LIC_ST_CV = 6'h08,
        LIC_ST_MAINT = 6'h10,
        LIC_ST_HALT = 6'h20
    } lic_state_e;

    // Analog side comparators
    typedef struct packed {
        logic main_detect;
        logic usb_supply_input;
        logic batt_below_trickle;
        logic batt_near_vcharge;
        logic current_below_eoc;
    } lic_sense_s;

    // Drive to the analog charger core
    typedef struct packed {
        logic main_path_en;
        logic usb_path_en;
        logic trickle_on;
        logic fast_on;
        logic cv_on;
        logic fast_from_rset;
        logic [1:0] usb_current_select;
        logic [1:0] vcharge_select;
    } lic_drive_s;
endpackage : lic_pkg

// *** testbench/lic_power_model.sv ***
`timescale 1ns/1ns
// Far side: power sources plus battery comparators
module lic_power_model (
    input wire logic main_on,
    input wire logic usb_on,
    input wire logic [12:0] batt_mv,
    input wire logic [6:0] i_pct,
    input wire lic_pkg::lic_drive_s drive,
    output lic_pkg::lic_sense_s sense
);
    import lic_pkg::*;

    logic [12:0] target_mv; // Charge voltage chosen by the device

    // Target follows the device's voltage code, not a bench guess
    always_comb begin
        case (drive.vcharge_select)
            2'h0: target_mv = 13'h1004; // 4.10 V
            2'h1: target_mv = 13'h1068; // 4.20 V
            2'h2: target_mv = 13'h10cc; // 4.30 V
            default: target_mv = 13'h10fe; // 4.35 V
        endcase
    end

    // Supply detectors
    assign sense.main_detect = main_on;
    assign sense.usb_supply_input = usb_on;
    // Threshold is fixed, software cannot move it
    assign sense.batt_below_trickle = batt_mv < 13'hb54;
    // Near means within 100 mV of target
    assign sense.batt_near_vcharge = (batt_mv + 13'h064) >= target_mv;
    // End of charge at ten percent of fast current
    assign sense.current_below_eoc = i_pct <= 7'h0a;
endmodule : lic_power_model

// *** testbench/lic_charge_sequencer_tb_top.sv ***
`timescale 1ns/1ns
module lic_charge_sequencer_tb_top;
    import lic_pkg::*;

    localparam longint WD_MIN = 20; // Shortened minute keeps run short
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic reg_wr = 1'b0;
    logic [1:0] reg_addr = 2'h2; // Parked on status
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic power_present_n;
    logic eoc_out;
    logic eoc_oe;
    logic wd_expired;
    logic main_on = 1'b0;
    logic usb_on = 1'b0;
    logic [12:0] batt_mv = 13'h9c4; // 2500 mV
    logic [6:0] i_pct = 7'h64; // Full current
    lic_sense_s sense;
    lic_drive_s drive;
    logic [7:0] d;
    int n_mismatch = 0;
    int checked = 0;
    int mins[4] = '{1, 15, 30, 60};
    wire logic eoc_pin = eoc_oe ? eoc_out : 1'b1; // Pull-up when released

    lic_charge_sequencer #(.WD_MINUTE_CYCLES(WD_MIN)) dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .sense(sense),
        .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .power_present_n(power_present_n), .end_of_charge_n_out(eoc_out), .end_of_charge_n_oe(eoc_oe),
        .drive(drive), .wd_expired(wd_expired));
    lic_power_model far_side (.main_on(main_on), .usb_on(usb_on), .batt_mv(batt_mv), .i_pct(i_pct),
        .drive(drive), .sense(sense));

    // Clock
    always #5 clk_sys = ~clk_sys;

    // Single compare point
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string msg);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %0t %s seen %h exp %h", $time, msg, seen, exp);
        end
    endtask : chk

    // One-cycle write strobe, then back to status
    task automatic wr(input logic [1:0] a, input logic [7:0] v);
        @(negedge clk_sys);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = v;
        @(negedge clk_sys);
        reg_wr = 1'b0;
        reg_addr = 2'h2;
    endtask : wr

    // Read data lands one edge after the address
    task automatic rd(input logic [1:0] a, output logic [7:0] v);
        @(negedge clk_sys);
        reg_addr = a;
        @(negedge clk_sys);
        v = reg_rdata;
        reg_addr = 2'h2;
    endtask : rd

    // Bounded poll of the state field
    task automatic wait_st(input logic [5:0] st, input int lim, input string msg);
        int i;
        i = 0;
        while (reg_rdata[5:0] !== st && i < lim) begin
            @(negedge clk_sys);
            i++;
        end
        repeat (2) @(negedge clk_sys); // Let drive outputs follow
        chk({2'h0, reg_rdata[5:0]}, {2'h0, st}, msg);
    endtask : wait_st

    // Reset values and refused accesses
    task automatic t_reset;
        rd(LIC_ADDR_CONFIG, d);
        chk(d, 8'h00, "config reset");
        rd(LIC_ADDR_CONTROL, d);
        chk(d, 8'h02, "control reset");
        wr(2'h3, 8'hff);
        wr(LIC_ADDR_STATUS, 8'hff);
        rd(2'h3, d);
        chk(d, 8'h00, "unmapped read");
        rd(LIC_ADDR_STATUS, d);
        chk(d, 8'h01, "status idle");
        wr(LIC_ADDR_CONTROL, 8'h12); // Refresh bit never stored
        rd(LIC_ADDR_CONTROL, d);
        chk(d, 8'h02, "refresh self clears");
        chk({7'h0, power_present_n}, 8'h01, "no power");
    endtask : t_reset

    // Power without enable charges nothing
    task automatic t_disabled;
        main_on = 1'b1;
        repeat (5) @(negedge clk_sys);
        chk({7'h0, power_present_n}, 8'h00, "power seen");
        chk({3'h0, drive[9:5]}, 8'h00, "disabled drive");
        chk(reg_rdata, 8'h01, "still idle");
        main_on = 1'b0;
        usb_on = 1'b1;
        repeat (3) @(negedge clk_sys);
        chk({7'h0, power_present_n}, 8'h00, "usb power seen");
        usb_on = 1'b0;
    endtask : t_disabled

    // Full wall cycle with fallback to trickle
    task automatic t_wall;
        main_on = 1'b1;
        batt_mv = 13'h9c4;
        wr(LIC_ADDR_CONTROL, 8'h03);
        wait_st(LIC_ST_TRICKLE, 6, "trickle start");
        chk({7'h0, eoc_pin}, 8'h00, "eoc low");
        chk({5'h0, drive.main_path_en, drive.trickle_on, drive.fast_on}, 8'h06, "trickle drive");
        repeat (30) @(negedge clk_sys); // Past one period: no expiry
        chk(reg_rdata, 8'h02, "watchdog off in trickle");
        batt_mv = 13'hdac;
        wait_st(LIC_ST_FAST, 6, "fast");
        wr(LIC_ADDR_CONTROL, 8'h13);
        chk({5'h0, drive.trickle_on, drive.fast_on, drive.fast_from_rset}, 8'h03, "fast drive");
        batt_mv = 13'h9c4;
        wait_st(LIC_ST_TRICKLE, 6, "fallback");
        chk(reg_rdata, 8'h42, "watchdog kept");
        wr(LIC_ADDR_CONTROL, 8'h13);
        batt_mv = 13'hfd2;
        wait_st(LIC_ST_CV, 10, "constant voltage");
        chk({7'h0, drive.cv_on}, 8'h01, "cv drive");
        i_pct = 7'h05;
        wait_st(LIC_ST_MAINT, 6, "maintenance");
        chk({7'h0, eoc_pin}, 8'h01, "eoc released");
        batt_mv = 13'hbb8;
        i_pct = 7'h64;
        repeat (10) @(negedge clk_sys);
        chk({2'h0, reg_rdata[5:0]}, 8'h10, "maintenance holds");
        wr(LIC_ADDR_CONTROL, 8'h02);
        wait_st(LIC_ST_IDLE, 6, "disable stops");
        chk({7'h0, eoc_pin}, 8'h01, "eoc open idle");
    endtask : t_wall

    // Every voltage and USB code, both supplies, then USB alone
    task automatic t_usb;
        batt_mv = 13'hdac;
        usb_on = 1'b1;
        wr(LIC_ADDR_CONTROL, 8'h01); // Watchdog off
        for (int k = 0; k < 4; k++) begin
            wr(LIC_ADDR_CONFIG, {k[1:0], 1'b1, k[1:0], 3'h0}); // USB via wall input
            wait_st(LIC_ST_FAST, 8, "fast usb");
            chk({6'h0, drive.vcharge_select}, 8'(k), "voltage code");
            chk({6'h0, drive.usb_current_select}, 8'(k), "usb current");
            chk({5'h0, drive.main_path_en, drive.usb_path_en, drive.fast_from_rset}, 8'h04, "wall path");
            chk({7'h0, drive.fast_on}, {7'h0, k != 3}, "usb off code");
        end
        repeat (40) @(negedge clk_sys);
        chk({2'h0, reg_rdata[5:0]}, 8'h04, "watchdog disabled");
        main_on = 1'b0;
        wr(LIC_ADDR_CONFIG, 8'h40);
        repeat (4) @(negedge clk_sys);
        chk({4'h0, drive.main_path_en, drive.usb_path_en, drive.fast_on, drive.fast_from_rset}, 8'h06,
            "usb only");
        chk({6'h0, drive.usb_current_select}, 8'h01, "usb only current");
        usb_on = 1'b0;
        wait_st(LIC_ST_IDLE, 6, "unplug stops");
        chk({7'h0, power_present_n}, 8'h01, "power gone");
        wr(LIC_ADDR_CONFIG, 8'h00);
    endtask : t_usb

    // Each period runs out, halts, and refresh recovers
    task automatic t_watchdog;
        main_on = 1'b1;
        wr(LIC_ADDR_CONTROL, 8'h03);
        wait_st(LIC_ST_FAST, 6, "fast for watchdog");
        for (int k = 0; k < 4; k++) begin
            wr(LIC_ADDR_CONTROL, {4'h1, k[1:0], 2'h3});
            repeat (mins[k] * WD_MIN - 6) @(negedge clk_sys);
            chk(reg_rdata, 8'h44, "no early expiry");
            wait_st(LIC_ST_HALT, 12, "expiry halts");
            chk({5'h0, wd_expired, drive.fast_on, drive.trickle_on}, 8'h04, "charge stopped");
            repeat (8) @(negedge clk_sys);
            chk({2'h0, reg_rdata[5:0]}, 8'h20, "halt held");
            wr(LIC_ADDR_CONTROL, {4'h1, k[1:0], 2'h3});
            wait_st(LIC_ST_FAST, 10, "refresh recovers");
        end
        main_on = 1'b0;
        wait_st(LIC_ST_IDLE, 6, "unplug");
    endtask : t_watchdog

    // Verdict and end of run
    task automatic final_report;
        if (n_mismatch == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : final_report

    // Hang guard, well past the expected few thousand cycles
    initial begin
        #200000;
        n_mismatch++;
        final_report();
    end

    // Main sequence
    initial begin
        repeat (8) @(negedge clk_sys);
        sys_rst = 1'b0;
        t_reset();
        t_disabled();
        t_wall();
        t_usb();
        t_watchdog();
        final_report();
    end
endmodule : lic_charge_sequencer_tb_top
